// file: efp_enc.sv
// efp_enc: behavioural pulse source, square track a, direction on b
// assumes the bench clock; pins change just after rising edges
`timescale 1ns/1ns
module efp_enc (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_half,
  input  wire logic        i_up,
  output logic             o_trk_a,
  output logic             o_trk_b,
  output logic [31:0]      o_rises
);
  logic [15:0] cnt;
  initial begin
    cnt = 16'h0000;
    o_trk_a = 1'b0;
    o_trk_b = 1'b0;
    o_rises = 32'h0000_0000;
  end
  // ==========================================================
  // track a toggles every i_half cycles while running
  always @(posedge i_clk) begin
    o_trk_b <= ~i_up;
    if (i_run && cnt + 16'h0001 >= i_half) begin
      cnt <= 16'h0000;
      o_trk_a <= ~o_trk_a;
      o_rises <= o_rises + {31'h0000_0000, ~o_trk_a};
    end else if (i_run) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// file: efp_gate.sv
// efp_gate: encoder counter with frequency, period and gate function
// assumes track, gate, index and reset pins are asynchronous to i_clk
// What this block does
// - count track a rising edges in window, then the next edge and its time
// - trailing edge wait time set in ms, default and maximum 1.6 s
// - frequency is reported as a magnitude, never negative
// - window defaults to 10 ms, at least one unit of its base
// - frequency uses the own free-running timebase only
// - gate freeze stops frequency measurement; period keeps running
// - index or external reset restarts frequency; old value kept
// - window base selects microseconds or milliseconds
// - window up to 600 ms uses edge-synchronised mode a
// - mode a starts at a rising edge, storing count and time
// - mode a waits for next edge up to wait time, divides
// - window above 600 ms uses mode b
// - mode b stores time and position at start and end, divides
// - period is the time between consecutive rising edges of a
// - period range 1.6 s, or 3.2 s when long range selected
// - no edge for the period range (1.6 s, or 3.2 s when long) discards the period value
// - gate 0 off, 1 freeze while high, 2 freeze while low
// - external reset clears the counter before the freeze applies
// - in up/down mode track b level gives the direction
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module efp_gate #(
  parameter int unsigned P_MS_CYC    = efp_pkg::MS_CYC,
  parameter int unsigned P_PER_S_CYC =
    efp_pkg::PER_SHORT_MS * efp_pkg::MS_CYC,
  parameter int unsigned P_PER_L_CYC =
    efp_pkg::PER_LONG_MS * efp_pkg::MS_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_trk_a,
  input  wire logic        i_trk_b,
  input  wire logic        i_gate,
  input  wire logic        i_idx,
  input  wire logic        i_ext_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata
);

  // ==========================================================
  // pin synchronisers and edge detection
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] prev_ff;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= {i_ext_rst, i_idx, i_gate, i_trk_b, i_trk_a};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  logic a_now, b_now, a_old, b_old, gate_in, a_rise;
  assign a_now   = sync2_ff[0];
  assign b_now   = sync2_ff[1];
  assign gate_in = sync2_ff[2];
  assign a_old   = prev_ff[0];
  assign b_old   = prev_ff[1];
  assign a_rise  = a_now & ~a_old;

  // ==========================================================
  // configuration registers
  logic [efp_pkg::CTL_W-1:0] ctrl_ff;
  logic [15:0]               window_ff;
  logic [15:0]               wait_ff;
  logic [1:0]                gate_mode;
  assign gate_mode = ctrl_ff[efp_pkg::CTL_GATE_LO +: 2];

  // ==========================================================
  // counter with gate and reset
  logic [31:0] count_ff;
  logic        frozen;
  logic        ext_edge;
  logic        idx_edge;
  logic        cnt_clear;
  logic        step;
  logic        up;

  assign frozen = (gate_mode == efp_pkg::GATE_HI &&  gate_in) ||
                  (gate_mode == efp_pkg::GATE_LO && !gate_in);
  assign ext_edge = ctrl_ff[efp_pkg::CTL_EXT_POS] ?
                    (sync2_ff[4] & ~prev_ff[4]) :
                    (~sync2_ff[4] & prev_ff[4]);
  assign idx_edge  = sync2_ff[3] & ~prev_ff[3];
  assign cnt_clear = (ctrl_ff[efp_pkg::CTL_EXT_EN] & ext_edge) |
                     (ctrl_ff[efp_pkg::CTL_IDX_EN] & idx_edge);

  always_comb begin
    if (ctrl_ff[efp_pkg::CTL_UPDOWN]) begin
      step = a_rise;
      up   = ~b_now;
    end else begin
      // 4x quadrature, a leading b counts up
      step = (a_now ^ a_old) ^ (b_now ^ b_old);
      up   = a_now ^ b_old;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_ff <= 32'h0000_0000;
    end else if (cnt_clear) begin
      count_ff <= 32'h0000_0000;
    end else if (step && !frozen) begin
      if (up ^ ctrl_ff[efp_pkg::CTL_REV]) begin
        count_ff <= count_ff + 32'h0000_0001;
      end else begin
        count_ff <= count_ff - 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // free-running microsecond and millisecond ticks
  logic [15:0] us_div_ff;
  logic [31:0] ms_div_ff;
  logic        us_tick;
  logic        ms_tick;
  assign us_tick = us_div_ff == 16'(efp_pkg::US_CYC - 1);
  assign ms_tick = ms_div_ff == P_MS_CYC - 1;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || us_tick) begin
      us_div_ff <= 16'h0000;
    end else begin
      us_div_ff <= us_div_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || ms_tick) begin
      ms_div_ff <= 32'h0000_0000;
    end else begin
      ms_div_ff <= ms_div_ff + 32'h0000_0001;
    end
  end

  // ==========================================================
  // frequency measurement, modes a and b
  efp_pkg::efp_state_t state_ff;
  logic        mode_b_ff;
  logic [15:0] win_cnt_ff;
  logic [15:0] wait_cnt_ff;
  logic [31:0] elapsed_ff;
  logic [31:0] edges_ff;
  logic [31:0] pos0_ff;
  logic [63:0] num_ff;
  logic [32:0] rem_ff;
  logic [6:0]  bit_ff;
  logic [31:0] freq_ff;
  logic        freq_vld_ff;
  logic [15:0] win_len;
  logic        base_tick;
  logic        mode_b_sel;
  logic        abort;
  logic [31:0] pos_diff, pos_mag;
  logic [32:0] rem_sh;

  assign win_len = (window_ff == 16'h0000) ? 16'h0001 : window_ff;
  assign base_tick = ctrl_ff[efp_pkg::CTL_WBASE] ? ms_tick : us_tick;
  assign mode_b_sel = ctrl_ff[efp_pkg::CTL_WBASE] &&
                      win_len > 16'(efp_pkg::MODE_A_MAX_MS);
  assign abort = cnt_clear || frozen;
  assign pos_diff = count_ff - pos0_ff;
  assign pos_mag  = pos_diff[31] ? 32'h0000_0000 - pos_diff : pos_diff;
  assign rem_sh = {rem_ff[31:0], num_ff[63]};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff    <= efp_pkg::EFP_IDLE;
      mode_b_ff   <= 1'b0;
      win_cnt_ff  <= 16'h0000;
      wait_cnt_ff <= 16'h0000;
      elapsed_ff  <= 32'h0000_0000;
      edges_ff    <= 32'h0000_0000;
      pos0_ff     <= 32'h0000_0000;
      num_ff      <= 64'h0000_0000_0000_0000;
      rem_ff      <= 33'h0_0000_0000;
      bit_ff      <= 7'h00;
    end else if (abort) begin
      state_ff <= efp_pkg::EFP_IDLE;
    end else begin
      case (state_ff)
        efp_pkg::EFP_IDLE: begin
          win_cnt_ff  <= 16'h0000;
          wait_cnt_ff <= 16'h0000;
          elapsed_ff  <= 32'h0000_0000;
          edges_ff    <= 32'h0000_0000;
          pos0_ff     <= count_ff;
          mode_b_ff   <= mode_b_sel;
          if (mode_b_sel || a_rise) begin
            state_ff <= efp_pkg::EFP_WIN;
          end
        end
        efp_pkg::EFP_WIN: begin
          elapsed_ff <= elapsed_ff + 32'h0000_0001;
          if (a_rise) begin
            edges_ff <= edges_ff + 32'h0000_0001;
          end
          if (base_tick) begin
            win_cnt_ff <= win_cnt_ff + 16'h0001;
            if (win_cnt_ff + 16'h0001 >= win_len) begin
              if (mode_b_ff) begin
                num_ff <= 64'(pos_mag) * 64'(efp_pkg::CLK_HZ);
                state_ff <= efp_pkg::EFP_DIV;
              end else begin
                state_ff <= efp_pkg::EFP_WAIT;
              end
              rem_ff <= 33'h0_0000_0000;
              bit_ff <= 7'h00;
            end
          end
        end
        efp_pkg::EFP_WAIT: begin
          elapsed_ff <= elapsed_ff + 32'h0000_0001;
          if (ms_tick) begin
            wait_cnt_ff <= wait_cnt_ff + 16'h0001;
          end
          if (a_rise) begin
            num_ff <= 64'(edges_ff + 32'h0000_0001)
                      * 64'(efp_pkg::CLK_HZ);
            elapsed_ff <= elapsed_ff + 32'h0000_0001;
            state_ff <= efp_pkg::EFP_DIV;
          end else if (wait_cnt_ff >= wait_ff) begin
            num_ff <= 64'(edges_ff) * 64'(efp_pkg::CLK_HZ);
            state_ff <= efp_pkg::EFP_DIV;
          end
        end
        efp_pkg::EFP_DIV: begin
          // edges or increments times clock rate over elapsed cycles
          num_ff <= {num_ff[62:0], 1'b0};
          if (rem_sh >= {1'b0, elapsed_ff}) begin
            rem_ff    <= rem_sh - {1'b0, elapsed_ff};
            num_ff[0] <= 1'b1;
          end else begin
            rem_ff <= rem_sh;
          end
          bit_ff <= bit_ff + 7'h01;
          if (bit_ff == 7'h3F) begin
            state_ff <= efp_pkg::EFP_IDLE;
          end
        end
        default: state_ff <= efp_pkg::EFP_IDLE;
      endcase
    end
  end

  // result is written in the same cycle as the last quotient bit
  logic [63:0] quot;
  assign quot = {num_ff[62:0], (rem_sh >= {1'b0, elapsed_ff})};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      freq_ff     <= 32'h0000_0000;
      freq_vld_ff <= 1'b0;
    end else if (!abort && state_ff == efp_pkg::EFP_DIV &&
                 bit_ff == 7'h3F) begin
      freq_vld_ff <= 1'b1;
      if (elapsed_ff == 32'h0000_0000) begin
        freq_ff <= 32'h0000_0000;
      end else if (quot[63:32] != 32'h0000_0000) begin
        freq_ff <= 32'hFFFF_FFFF;
      end else begin
        freq_ff <= quot[31:0];
      end
    end
  end

  // ==========================================================
  // period measurement, runs regardless of the gate
  logic [31:0] per_cyc_ff;
  logic [31:0] period_ff;
  logic        per_seen_ff;
  logic        per_vld_ff;
  logic [31:0] per_lim;
  logic [63:0] per_ns;
  assign per_lim = ctrl_ff[efp_pkg::CTL_PLONG] ? P_PER_L_CYC
                                               : P_PER_S_CYC;
  assign per_ns = 64'(per_cyc_ff + 32'h0000_0001) *
                  64'(efp_pkg::CLK_PERIOD_NS);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      per_cyc_ff  <= 32'h0000_0000;
      period_ff   <= 32'h0000_0000;
      per_seen_ff <= 1'b0;
      per_vld_ff  <= 1'b0;
    end else if (a_rise) begin
      per_cyc_ff  <= 32'h0000_0000;
      per_seen_ff <= 1'b1;
      if (per_seen_ff) begin
        period_ff  <= per_ns[31:0];
        per_vld_ff <= 1'b1;
      end
    end else if (per_cyc_ff >= per_lim) begin
      period_ff   <= 32'h0000_0000;
      per_vld_ff  <= 1'b0;
      per_seen_ff <= 1'b0;
    end else begin
      per_cyc_ff <= per_cyc_ff + 32'h0000_0001;
    end
  end

  // ==========================================================
  // ahb-lite slave: writes zero wait, reads one wait state
  logic       dp_wr_ff;
  logic       dp_rd_ff;
  logic       rd_wait_ff;
  logic [7:0] dp_addr_ff;
  logic       addr_ok;
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dp_wr_ff   <= 1'b0;
      dp_rd_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else if (o_hreadyout) begin
      dp_wr_ff   <= addr_ok && i_hwrite;
      dp_rd_ff   <= addr_ok && !i_hwrite;
      dp_addr_ff <= {i_haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_wait_ff <= 1'b0;
    end else begin
      rd_wait_ff <= dp_rd_ff && !rd_wait_ff;
    end
  end

  assign o_hreadyout = !(dp_rd_ff && !rd_wait_ff);
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_ff   <= efp_pkg::CTRL_RST;
      window_ff <= efp_pkg::WINDOW_RST;
      wait_ff   <= efp_pkg::WAIT_RST;
    end else if (dp_wr_ff) begin
      case (dp_addr_ff)
        efp_pkg::OFS_CTRL:   ctrl_ff   <= i_hwdata[efp_pkg::CTL_W-1:0];
        efp_pkg::OFS_WINDOW: window_ff <= i_hwdata[15:0];
        efp_pkg::OFS_WAIT: begin
          if (i_hwdata[15:0] > 16'(efp_pkg::WAIT_MAX_MS)) begin
            wait_ff <= 16'(efp_pkg::WAIT_MAX_MS);
          end else begin
            wait_ff <= i_hwdata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (dp_addr_ff)
      efp_pkg::OFS_CTRL:   rd_mux = 32'(ctrl_ff);
      efp_pkg::OFS_WINDOW: rd_mux = {16'h0000, window_ff};
      efp_pkg::OFS_WAIT:   rd_mux = {16'h0000, wait_ff};
      efp_pkg::OFS_STATUS: rd_mux = {26'h000_0000, state_ff,
                                     per_vld_ff, freq_vld_ff,
                                     frozen, mode_b_ff};
      efp_pkg::OFS_COUNT:  rd_mux = count_ff;
      efp_pkg::OFS_FREQ:   rd_mux = freq_ff;
      efp_pkg::OFS_PERIOD: rd_mux = period_ff;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (dp_rd_ff && !rd_wait_ff) begin
      o_hrdata <= rd_mux;
    end
  end

endmodule

// file: efp_gate_properties.sv
// efp_chk: bus timing and read-value checks on the efp_gate ports
// assumes one clock domain; bound to every efp_gate instance
`timescale 1ns/1ns
module efp_chk #(
  parameter int unsigned P_PER_L_CYC = 4000
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata
);
  logic       acc;
  logic [7:0] ra_ff;
  assign acc = i_hsel & i_htrans[1] & i_hready & o_hreadyout;
  // address of the read now in its data phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) ra_ff <= 8'h00;
    else if (acc && !i_hwrite) ra_ff <= i_haddr[7:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_take;
    acc && !i_hwrite;
  endsequence
  sequence s_rd_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  sequence s_rd_of(logic [7:0] a);
    !o_hreadyout && ra_ff == a;
  endsequence
  // ==========================================================
  // bus timing
  a_read_wait: assert property (s_rd_take |=> s_rd_answer)
    else $error("read wait state wrong");
  a_write_fast: assert property (acc && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property (!o_hreadyout |-> $past(acc && !i_hwrite))
    else $error("stall without read");
  a_rdata_hold: assert property (o_hreadyout |=> $stable(o_hrdata))
    else $error("read data moved");
  a_resp_okay: assert property (!o_hresp)
    else $error("error response");
  a_reset_idle: assert property ($fell(i_sys_rst) |->
    o_hreadyout && o_hrdata == 32'h0000_0000)
    else $error("bad state after reset");
  // ==========================================================
  // read values
  a_wait_clamp: assert property (s_rd_of(efp_pkg::OFS_WAIT) |=>
    o_hrdata <= efp_pkg::WAIT_MAX_MS)
    else $error("wait above maximum");
  a_period_grain: assert property (s_rd_of(efp_pkg::OFS_PERIOD) |=>
    o_hrdata[2:0] == 3'h0 && o_hrdata <= P_PER_L_CYC * 40)
    else $error("period out of range");
  a_window_width: assert property (s_rd_of(efp_pkg::OFS_WINDOW) |=>
    o_hrdata[31:16] == 16'h0000)
    else $error("window too wide");
endmodule
bind efp_gate efp_chk #(.P_PER_L_CYC(P_PER_L_CYC)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_hrdata(o_hrdata));

// file: efp_pkg.sv
// efp_pkg: register map, field layout, reset values and timing constants
// assumes a single 25 MHz clock domain and an ahb-lite register port
package efp_pkg;

  // ==========================================================
  // clock and time units
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned US_CYC        =
    (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_US         = 1000;
  localparam int unsigned MS_CYC        = MS_US * US_CYC;
  localparam int unsigned WAIT_MAX_MS   = 1600;
  localparam int unsigned MODE_A_MAX_MS = 600;
  localparam int unsigned PER_SHORT_MS  = 1600;
  localparam int unsigned PER_LONG_MS   = 3200;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WINDOW = 8'h04;
  localparam logic [7:0] OFS_WAIT   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_FREQ   = 8'h14;
  localparam logic [7:0] OFS_PERIOD = 8'h18;

  // ==========================================================
  // control fields
  localparam int CTL_UPDOWN  = 0;
  localparam int CTL_WBASE   = 1;
  localparam int CTL_GATE_LO = 2;
  localparam int CTL_IDX_EN  = 4;
  localparam int CTL_EXT_EN  = 5;
  localparam int CTL_EXT_POS = 6;
  localparam int CTL_PLONG   = 7;
  localparam int CTL_REV     = 8;
  localparam int CTL_W       = 9;
  localparam logic [8:0]  CTRL_RST   = 9'h000;
  localparam logic [15:0] WINDOW_RST = 16'h2710;
  localparam logic [15:0] WAIT_RST   = 16'h0640;

  // gate settings
  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_HI  = 2'h1;
  localparam logic [1:0] GATE_LO  = 2'h2;

  typedef enum logic [1:0] {
    EFP_IDLE,
    EFP_WIN,
    EFP_WAIT,
    EFP_DIV
  } efp_state_t;

endpackage

// file: tb_top.sv
// tb_top: self-checking bench for efp_gate with a pulse source
// assumes efp_pkg, efp_enc and the bound checker are compiled first
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst, gate, idx, ext, hsel, hwrite, run, up;
  logic        trk_a, trk_b, hrdy, hresp;
  logic [1:0]  htrans;
  logic [15:0] half;
  logic [31:0] haddr, hwdata, hrdata, rises, q, c1, r1;
  int          miscompares, num_checks;

  efp_gate #(.P_MS_CYC(25), .P_PER_S_CYC(2000), .P_PER_L_CYC(4000)) DUT (
    .i_clk(clk), .i_sys_rst(rst), .i_trk_a(trk_a), .i_trk_b(trk_b),
    .i_gate(gate), .i_idx(idx), .i_ext_rst(ext), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata));
  efp_enc ENC (.i_clk(clk), .i_run(run), .i_half(half), .i_up(up),
    .o_trk_a(trk_a), .o_trk_b(trk_b), .o_rises(rises));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h", $time, m, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // single ahb-lite word transfer; read data lands in q
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    ahb(0, efp_pkg::OFS_WINDOW, '0);
    chk(q, 32'h0000_2710, "window reset");
    ahb(0, efp_pkg::OFS_WAIT, '0);
    chk(q, 32'h0000_0640, "wait reset");
    ahb(1, efp_pkg::OFS_WAIT, 32'h0000_0641);
    ahb(0, efp_pkg::OFS_WAIT, '0);
    chk(q, 32'h0000_0640, "wait clamp");
    ahb(0, 8'h40, '0);
    chk(q, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_period();
    half <= 16'h000A;
    run <= 1'b1;
    wt(200);
    ahb(0, efp_pkg::OFS_PERIOD, '0);
    chk(q, 32'h0000_0320, "period");
    run <= 1'b0;
    wt(2100);
    ahb(0, efp_pkg::OFS_PERIOD, '0);
    chk(q, 32'h0000_0000, "period drop");
    ahb(1, efp_pkg::OFS_CTRL, 32'h0000_0080);
    half <= 16'h05DC;
    run <= 1'b1;
    wt(7000);
    ahb(0, efp_pkg::OFS_PERIOD, '0);
    chk(q, 32'h0001_D4C0, "long period");
  endtask
  task automatic t_freq();
    ahb(1, efp_pkg::OFS_CTRL, 32'h0000_0003);
    ahb(1, efp_pkg::OFS_WINDOW, 32'h0000_0002);
    half <= 16'h0005;
    up <= 1'b1;
    wt(600);
    ahb(0, efp_pkg::OFS_FREQ, '0);
    chk(q, 32'h0026_25A0, "mode a");
    ahb(0, efp_pkg::OFS_STATUS, '0);
    chk(q[0], 1'b0, "mode a select");
    half <= 16'h0004;
    up <= 1'b0;
    wt(600);
    ahb(0, efp_pkg::OFS_FREQ, '0);
    chk(q, 32'h002F_AF08, "reverse");
    half <= 16'h0005;
    up <= 1'b0;
    ahb(1, efp_pkg::OFS_WINDOW, 32'h0000_0259);
    wt(31000);
    ahb(0, efp_pkg::OFS_FREQ, '0);
    chk(q > 32'h0026_1DD0 && q < 32'h0026_2D70, 1'b1, "mode b");
    ahb(0, efp_pkg::OFS_STATUS, '0);
    chk(q[0], 1'b1, "mode b select");
    ahb(1, efp_pkg::OFS_WINDOW, 32'h0000_0002);
    // no edge inside a 2 ms window and a 1 ms wait gives zero
    ahb(1, efp_pkg::OFS_WAIT, 32'h0000_0001);
    half <= 16'h0064;
    wt(1000);
    ahb(0, efp_pkg::OFS_FREQ, '0);
    chk(q, 32'h0000_0000, "wait timeout");
    half <= 16'h0005;
    ahb(1, efp_pkg::OFS_WAIT, 32'h0000_0640);
  endtask
  task automatic t_dir();
    for (int i = 0; i < 2; i++) begin
      run <= 1'b0;
      up <= i[0];
      wt(10);
      ahb(0, efp_pkg::OFS_COUNT, '0);
      c1 = q;
      r1 = rises;
      run <= 1'b1;
      wt(200);
      run <= 1'b0;
      wt(10);
      ahb(0, efp_pkg::OFS_COUNT, '0);
      chk(i ? q - c1 : c1 - q, rises - r1, "direction");
    end
  endtask
  task automatic t_gate();
    logic [31:0] f0;
    up <= 1'b1;
    run <= 1'b1;
    wt(600);
    ahb(0, efp_pkg::OFS_FREQ, '0);
    chk(q, 32'h0026_25A0, "freq before gate");
    f0 = q;
    for (int g = 0; g < 3; g++) begin
      ahb(1, efp_pkg::OFS_CTRL,
          32'h0000_0043 | (g << 2) | ((g == 1) << 5) | ((g == 2) << 4));
      gate <= (g != 2);
      wt(20);
      ahb(0, efp_pkg::OFS_STATUS, '0);
      chk(q[1], g != 0, "frozen flag");
      ahb(0, efp_pkg::OFS_COUNT, '0);
      c1 = q;
      wt(100);
      ahb(0, efp_pkg::OFS_COUNT, '0);
      chk(q == c1, g != 0, "count hold");
      ahb(0, efp_pkg::OFS_PERIOD, '0);
      chk(q, 32'h0000_0190, "period runs");
      ext <= (g == 1);
      idx <= (g == 2);
      wt(10);
      ext <= 1'b0;
      idx <= 1'b0;
      ahb(0, efp_pkg::OFS_COUNT, '0);
      if (g != 0) chk(q, 32'h0000_0000, "clear");
      ahb(0, efp_pkg::OFS_FREQ, '0);
      chk(q, f0, "freq kept");
    end
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    {gate, idx, ext, hwrite, run, up} = '0;
    hsel = 1'b1;
    htrans = 2'b00;
    half = 16'h000A;
    haddr = '0;
    hwdata = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_period();
    t_freq();
    t_dir();
    t_gate();
    stop_test();
  end
  initial begin
    #(40 * 90000);
    miscompares++;
    stop_test();
  end
endmodule
